// ==== logic/ebpm_defines.svh ====
`ifndef EBPM_DEFINES_SVH
`define EBPM_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EBPM_OFS_BUS_CTRL 8'h00
`define EBPM_OFS_PB_PER 8'h04
`define EBPM_OFS_PB_DDR 8'h08
`define EBPM_OFS_PB_DATA 8'h0C
`define EBPM_OFS_PB_PUR 8'h10
`define EBPM_OFS_PF_PER 8'h14
`define EBPM_OFS_PF_DDR 8'h18
`define EBPM_OFS_PF_DATA 8'h1C
`define EBPM_OFS_PF_PUR 8'h20
`define EBPM_OFS_STATUS 8'h24
// ----------------------------------------
// field positions
// ----------------------------------------
`define EBPM_BIT_DRV 0
`define EBPM_BIT_PB0 0
`define EBPM_PF_LSB 9
`define EBPM_PF_MSB 15
`define EBPM_ST_EXTERNAL_BOOT_STRAP 0
`define EBPM_ST_MODE 1
`define EBPM_ST_SECURE 2
`define EBPM_ST_ADDR 3
`define EBPM_ST_PB_BUS 4
// ----------------------------------------
// reset values
// ----------------------------------------
`define EBPM_RST_DRV 1'b0
`define EBPM_RST_PB_PER 1'b1
`define EBPM_RST_PB_DDR 1'b0
`define EBPM_RST_PB_DOUT 1'b0
`define EBPM_RST_PB_PUR 1'b1
`define EBPM_RST_PF_PER 7'h7F
`define EBPM_RST_PF_DDR 7'h00
`define EBPM_RST_PF_DOUT 7'h00
`define EBPM_RST_PF_PUR 7'h7F
`endif

// ==== logic/ebpm_pkg.sv ====
package ebpm_pkg;
	// ----------------------------------------
	// bus carriers
	// ----------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ebpm_apb_req_t;
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} ebpm_apb_rsp_t;
	// ----------------------------------------
	// pad control and pad drive
	// ----------------------------------------
	typedef struct packed {
		logic bus_sel;
		logic gpio_dir;
		logic gpio_out;
		logic bus_out;
		logic bus_oe;
		logic pu_en;
	} ebpm_pad_ctl_t;
	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
	} ebpm_pad_drv_t;
	typedef struct packed {
		logic sync1;
		logic sync2;
		ebpm_pad_drv_t drv;
	} ebpm_pad_st_t;
	// ----------------------------------------
	// top-level state
	// ----------------------------------------
	typedef struct packed {
		logic drv;
		logic pb_per;
		logic pb_ddr;
		logic pb_dout;
		logic pb_pur;
		logic [6:0] pf_per;
		logic [6:0] pf_ddr;
		logic [6:0] pf_dout;
		logic [6:0] pf_pur;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic [2:0] strap_lat;
		logic boot_pending;
		logic ctrl_oe;
		logic [31:0] rdata;
		logic err;
	} ebpm_top_st_t;
endpackage

// ==== logic/ebpm_pad.sv ====
`timescale 1ns/1ps
module ebpm_pad (
	input wire logic clk,
	input wire logic rst,
	input ebpm_pkg::ebpm_pad_ctl_t ctl,
	input wire logic pin_in,
	output ebpm_pkg::ebpm_pad_drv_t drv,
	output logic gpio_in,
	output logic bus_in
);
	import ebpm_pkg::*;

	ebpm_pad_st_t st_ff;
	ebpm_pad_st_t nxt_st;

	// ----------------------------------------
	// pad mux and input synchroniser
	// ----------------------------------------
	// sync stages shift through reset so the pin level is valid at release
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = pin_in;
		nxt_st.sync2 = st_ff.sync1;
		if (ctl.bus_sel) begin
			nxt_st.drv.out = ctl.bus_out;
			nxt_st.drv.oe = ctl.bus_oe;
		end else begin
			nxt_st.drv.out = ctl.gpio_out;
			nxt_st.drv.oe = ctl.gpio_dir;
		end
		nxt_st.drv.pu = ctl.pu_en;
		if (rst) begin
			nxt_st.drv.out = 1'b0;
			nxt_st.drv.oe = 1'b0;
			nxt_st.drv.pu = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// the unselected function sees a constant zero, never the pin
	assign drv = st_ff.drv;
	assign gpio_in = st_ff.sync2 & ~ctl.bus_sel;
	assign bus_in = st_ff.sync2 & ctl.bus_sel;
endmodule

// ==== logic/ebpm_top.sv ====
// Operation
// - Software can make port B line zero an input or an output while it is in GPIO mode.
// - While the external bus is idle the top address line and control outputs float unless the drive bit is set.
// - At reset release the boot strap, mode strap and flash security pick GPIO or address for port B line zero.
// - A write to the port B peripheral select overrides the strap choice at any time.
// - Clearing bit 0 of the port B pull-up register turns off that line's pull-up.
// - While the external bus is idle data lines zero to six float unless the drive bit is set.
// - Software sets each of the seven shared port F lines as input or output individually.
// - After reset the seven shared port F lines belong to the data bus, not to GPIO.
// - Each port F pull-up bit maps to one data line, bit 9 being data line zero and bit 15 data line six.
// - During reset shared lines default to bus function with outputs off and pull-ups on.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ebpm_defines.svh"
module ebpm_top (
	input wire logic MCLK,
	input wire logic RST,
	// register bus
	input ebpm_pkg::ebpm_apb_req_t APB_REQ,
	output ebpm_pkg::ebpm_apb_rsp_t APB_RSP,
	// external memory interface core, same clock
	input wire logic EMI_BUS_ACTIVE,
	input wire logic EMI_DATA_WR,
	input wire logic EMI_ADDR_TOP,
	input wire logic [6:0] EMI_DATA_OUT,
	output logic [6:0] EMI_DATA_IN,
	output logic EMI_CTRL_OE,
	// straps, asynchronous
	input wire logic EXT_BOOT_STRAP,
	input wire logic MODE_STRAP,
	input wire logic FLASH_SECURED,
	// pins: bit 0 port B line zero, bits 7:1 data lines 0..6
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE,
	output logic [7:0] PIN_PU
);
	import ebpm_pkg::*;

	localparam int NPAD = 8;

	ebpm_top_st_t st_ff;
	ebpm_top_st_t nxt_st;
	ebpm_pad_ctl_t [NPAD-1:0] pad_ctl;
	ebpm_pad_drv_t [NPAD-1:0] pad_drv;
	logic [NPAD-1:0] gpio_in;
	logic [NPAD-1:0] bus_in;
	logic strap_addr;
	logic setup_ph;
	logic wr_en;
	logic hit;
	logic [31:0] rd_val;
	logic [31:0] wd;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// zero wait states: data is prepared in the setup cycle
	assign setup_ph = APB_REQ.psel & ~APB_REQ.penable;
	assign wr_en = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
	assign wd = APB_REQ.pwdata;
	assign APB_RSP.pready = 1'b1;
	assign APB_RSP.prdata = st_ff.rdata;
	assign APB_RSP.pslverr = st_ff.err;

	// ----------------------------------------
	// strap decision
	// ----------------------------------------
	// external boot always needs the address line; otherwise the
	// interface mode asks for it, but a secured flash keeps it as GPIO
	assign strap_addr = st_ff.strap_s2[`EBPM_ST_EXTERNAL_BOOT_STRAP] |
		(st_ff.strap_s2[`EBPM_ST_MODE] & ~st_ff.strap_s2[`EBPM_ST_SECURE]);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (APB_REQ.paddr)
			`EBPM_OFS_BUS_CTRL: begin
				rd_val[`EBPM_BIT_DRV] = st_ff.drv;
			end
			`EBPM_OFS_PB_PER: begin
				rd_val[`EBPM_BIT_PB0] = st_ff.pb_per;
			end
			`EBPM_OFS_PB_DDR: begin
				rd_val[`EBPM_BIT_PB0] = st_ff.pb_ddr;
			end
			`EBPM_OFS_PB_DATA: begin
				rd_val[`EBPM_BIT_PB0] = gpio_in[0];
			end
			`EBPM_OFS_PB_PUR: begin
				rd_val[`EBPM_BIT_PB0] = st_ff.pb_pur;
			end
			`EBPM_OFS_PF_PER: begin
				rd_val[`EBPM_PF_MSB:`EBPM_PF_LSB] = st_ff.pf_per;
			end
			`EBPM_OFS_PF_DDR: begin
				rd_val[`EBPM_PF_MSB:`EBPM_PF_LSB] = st_ff.pf_ddr;
			end
			`EBPM_OFS_PF_DATA: begin
				rd_val[`EBPM_PF_MSB:`EBPM_PF_LSB] = gpio_in[7:1];
			end
			`EBPM_OFS_PF_PUR: begin
				rd_val[`EBPM_PF_MSB:`EBPM_PF_LSB] = st_ff.pf_pur;
			end
			`EBPM_OFS_STATUS: begin
				rd_val[`EBPM_ST_EXTERNAL_BOOT_STRAP] = st_ff.strap_lat[`EBPM_ST_EXTERNAL_BOOT_STRAP];
				rd_val[`EBPM_ST_MODE] = st_ff.strap_lat[`EBPM_ST_MODE];
				rd_val[`EBPM_ST_SECURE] = st_ff.strap_lat[`EBPM_ST_SECURE];
				rd_val[`EBPM_ST_ADDR] = st_ff.strap_lat[`EBPM_ST_EXTERNAL_BOOT_STRAP] |
					(st_ff.strap_lat[`EBPM_ST_MODE] & ~st_ff.strap_lat[`EBPM_ST_SECURE]);
				rd_val[`EBPM_ST_PB_BUS] = st_ff.pb_per;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// strap synchroniser keeps running in reset so it is settled at release
		nxt_st.strap_s1 = {FLASH_SECURED, MODE_STRAP, EXT_BOOT_STRAP};
		nxt_st.strap_s2 = st_ff.strap_s1;
		// control strobes float while idle unless the drive bit holds them
		nxt_st.ctrl_oe = EMI_BUS_ACTIVE | st_ff.drv;
		if (setup_ph) begin
			nxt_st.rdata = APB_REQ.pwrite ? 32'h0000_0000 : rd_val;
			nxt_st.err = ~hit;
		end
		// one-shot strap capture in the first cycle after release
		if (st_ff.boot_pending) begin
			nxt_st.pb_per = strap_addr;
			nxt_st.strap_lat = st_ff.strap_s2;
			nxt_st.boot_pending = 1'b0;
		end
		if (wr_en) begin
			case (APB_REQ.paddr)
				`EBPM_OFS_BUS_CTRL: begin
					nxt_st.drv = wd[`EBPM_BIT_DRV];
				end
				`EBPM_OFS_PB_PER: begin
					nxt_st.pb_per = wd[`EBPM_BIT_PB0];
				end
				`EBPM_OFS_PB_DDR: begin
					nxt_st.pb_ddr = wd[`EBPM_BIT_PB0];
				end
				`EBPM_OFS_PB_DATA: begin
					nxt_st.pb_dout = wd[`EBPM_BIT_PB0];
				end
				`EBPM_OFS_PB_PUR: begin
					nxt_st.pb_pur = wd[`EBPM_BIT_PB0];
				end
				`EBPM_OFS_PF_PER: begin
					nxt_st.pf_per = wd[`EBPM_PF_MSB:`EBPM_PF_LSB];
				end
				`EBPM_OFS_PF_DDR: begin
					nxt_st.pf_ddr = wd[`EBPM_PF_MSB:`EBPM_PF_LSB];
				end
				`EBPM_OFS_PF_DATA: begin
					nxt_st.pf_dout = wd[`EBPM_PF_MSB:`EBPM_PF_LSB];
				end
				`EBPM_OFS_PF_PUR: begin
					nxt_st.pf_pur = wd[`EBPM_PF_MSB:`EBPM_PF_LSB];
				end
				default: begin
					nxt_st.err = st_ff.err;
				end
			endcase
		end
		if (RST) begin
			nxt_st.drv = `EBPM_RST_DRV;
			nxt_st.pb_per = `EBPM_RST_PB_PER;
			nxt_st.pb_ddr = `EBPM_RST_PB_DDR;
			nxt_st.pb_dout = `EBPM_RST_PB_DOUT;
			nxt_st.pb_pur = `EBPM_RST_PB_PUR;
			nxt_st.pf_per = `EBPM_RST_PF_PER;
			nxt_st.pf_ddr = `EBPM_RST_PF_DDR;
			nxt_st.pf_dout = `EBPM_RST_PF_DOUT;
			nxt_st.pf_pur = `EBPM_RST_PF_PUR;
			nxt_st.strap_lat = 3'h0;
			nxt_st.boot_pending = 1'b1;
			nxt_st.ctrl_oe = 1'b0;
			nxt_st.rdata = 32'h0000_0000;
			nxt_st.err = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		st_ff <= nxt_st;
	end

	// ----------------------------------------
	// pad control
	// ----------------------------------------
	// data lines drive on a write cycle only; when idle the drive bit
	// decides whether EMI_DATA_OUT is driven or the lines float
	always_comb begin
		pad_ctl[0].bus_sel = st_ff.pb_per;
		pad_ctl[0].gpio_dir = st_ff.pb_ddr;
		pad_ctl[0].gpio_out = st_ff.pb_dout;
		pad_ctl[0].bus_out = EMI_ADDR_TOP;
		pad_ctl[0].bus_oe = EMI_BUS_ACTIVE | st_ff.drv;
		pad_ctl[0].pu_en = st_ff.pb_pur;
		for (int i = 1; i < NPAD; i++) begin
			pad_ctl[i].bus_sel = st_ff.pf_per[i-1];
			pad_ctl[i].gpio_dir = st_ff.pf_ddr[i-1];
			pad_ctl[i].gpio_out = st_ff.pf_dout[i-1];
			pad_ctl[i].bus_out = EMI_DATA_OUT[i-1];
			pad_ctl[i].bus_oe = EMI_BUS_ACTIVE ? EMI_DATA_WR : st_ff.drv;
			pad_ctl[i].pu_en = st_ff.pf_pur[i-1];
		end
	end

	// ----------------------------------------
	// pad cells
	// ----------------------------------------
	for (genvar g = 0; g < NPAD; g++) begin : g_pad
		ebpm_pad u_pad (
			.clk(MCLK),
			.rst(RST),
			.ctl(pad_ctl[g]),
			.pin_in(PIN_IN[g]),
			.drv(pad_drv[g]),
			.gpio_in(gpio_in[g]),
			.bus_in(bus_in[g])
		);
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < NPAD; i++) begin
			PIN_OUT[i] = pad_drv[i].out;
			PIN_OE[i] = pad_drv[i].oe;
			PIN_PU[i] = pad_drv[i].pu;
		end
	end

	// bus side sees zero on any line handed to GPIO
	assign EMI_DATA_IN = bus_in[7:1];
	assign EMI_CTRL_OE = st_ff.ctrl_oe;
endmodule

// ==== verification/ebpm_top_monitor.sv ====
`timescale 1ns/1ps
`include "ebpm_defines.svh"
module ebpm_top_monitor (
	input wire logic MCLK,
	input wire logic RST,
	input ebpm_pkg::ebpm_apb_req_t APB_REQ,
	input ebpm_pkg::ebpm_apb_rsp_t APB_RSP,
	input wire logic EMI_BUS_ACTIVE,
	input wire logic EMI_DATA_WR,
	input wire logic [6:0] EMI_DATA_OUT,
	input wire logic EMI_CTRL_OE,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE,
	input wire logic [7:0] PIN_PU
);
	import ebpm_pkg::*;
	logic drv_ff;
	logic [6:0] pf_ff;
	logic wr_hit;
	logic bad_addr;
	// ----------------------------------------
	// shadows of drive bit and port F select
	// ----------------------------------------
	assign wr_hit = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
	assign bad_addr = APB_REQ.paddr > 8'h24 || APB_REQ.paddr[1:0] != 2'h0;
	// mirrors the registers so bus-mode lines are known without peeking inside
	always_ff @(posedge MCLK) begin
		if (RST) begin
			drv_ff <= 1'h0;
			pf_ff <= 7'h7F;
		end else if (wr_hit && APB_REQ.paddr == `EBPM_OFS_BUS_CTRL) begin
			drv_ff <= APB_REQ.pwdata[0];
		end else if (wr_hit && APB_REQ.paddr == `EBPM_OFS_PF_PER) begin
			pf_ff <= APB_REQ.pwdata[15:9];
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	sequence s_setup;
		APB_REQ.psel && !APB_REQ.penable;
	endsequence
	a_reset_pins_off: assert property ($fell(RST) |-> PIN_OE == 8'h00 && PIN_PU == 8'hFF)
		else $error("pins not safe after reset");
	a_bad_addr_err: assert property (s_setup ##0 bad_addr |=> APB_RSP.pslverr)
		else $error("no error on bad address");
	a_ctrl_oe_track: assert property (1'h1 |=> EMI_CTRL_OE == ($past(EMI_BUS_ACTIVE) || $past(drv_ff)))
		else $error("control enable wrong");
	a_write_drive: assert property (EMI_BUS_ACTIVE && EMI_DATA_WR |=> (PIN_OE[7:1] & $past(pf_ff)) == $past(pf_ff)
		&& ((PIN_OUT[7:1] ^ $past(EMI_DATA_OUT)) & $past(pf_ff)) == 7'h00) else $error("write data not driven");
	a_read_float: assert property (EMI_BUS_ACTIVE && !EMI_DATA_WR |=> (PIN_OE[7:1] & $past(pf_ff)) == 7'h00)
		else $error("data driven in read");
	a_idle_float: assert property (!EMI_BUS_ACTIVE && !drv_ff |=> (PIN_OE[7:1] & $past(pf_ff)) == 7'h00)
		else $error("idle data not floating");
	a_idle_drive: assert property (!EMI_BUS_ACTIVE && drv_ff |=> (PIN_OE[7:1] & $past(pf_ff)) == $past(pf_ff))
		else $error("idle data not driven");
	a_gpio_keeps_oe: assert property ($rose(EMI_BUS_ACTIVE) |=> ((PIN_OE[7:1] ^ $past(PIN_OE[7:1])) & ~$past(pf_ff)) == 7'h00)
		else $error("gpio line moved by bus");
endmodule
bind ebpm_top ebpm_top_monitor u_mon (.MCLK(MCLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.EMI_BUS_ACTIVE(EMI_BUS_ACTIVE), .EMI_DATA_WR(EMI_DATA_WR), .EMI_DATA_OUT(EMI_DATA_OUT),
	.EMI_CTRL_OE(EMI_CTRL_OE), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PU(PIN_PU));

// ==== verification/ebpm_mem_model.sv ====
`timescale 1ns/1ps
module ebpm_mem_model (
	input wire logic clk,
	input wire logic drive_en,
	input wire logic [7:0] drive_val,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pu,
	output logic [7:0] pin_lvl
);
	logic [7:0] last_ff;
	// remembers the wire so an undriven, unpulled line can toggle
	always_ff @(posedge clk) begin
		last_ff <= pin_lvl;
	end
	// device drive wins, then the memory, then the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) begin
				pin_lvl[i] = pin_out[i];
			end else if (drive_en) begin
				pin_lvl[i] = drive_val[i];
			end else if (pin_pu[i]) begin
				pin_lvl[i] = 1'h1;
			end else begin
				pin_lvl[i] = ~last_ff[i]; // floating: never a stable guess
			end
		end
	end
endmodule

// ==== verification/ebpm_top_tb.sv ====
`timescale 1ns/1ps
`include "ebpm_defines.svh"
module ebpm_top_tb;
	import ebpm_pkg::*;
	logic mclk, rst, act, wr, atop, boot, mode, sec, mem_en, ctl, e;
	logic [6:0] dout, din;
	logic [7:0] mval, pin_in, pout, poe, ppu;
	logic [31:0] q;
	ebpm_apb_req_t req;
	ebpm_apb_rsp_t rsp;
	int fails, n_checks;
	ebpm_top dut (.MCLK(mclk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp), .EMI_BUS_ACTIVE(act), .EMI_DATA_WR(wr),
		.EMI_ADDR_TOP(atop), .EMI_DATA_OUT(dout), .EMI_DATA_IN(din), .EMI_CTRL_OE(ctl), .EXT_BOOT_STRAP(boot),
		.MODE_STRAP(mode), .FLASH_SECURED(sec), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe), .PIN_PU(ppu));
	ebpm_mem_model mem (.clk(mclk), .drive_en(mem_en), .drive_val(mval), .pin_out(pout), .pin_oe(poe),
		.pin_pu(ppu), .pin_lvl(pin_in));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task report_and_stop;
		if (fails == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			fails++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	// one APB transfer; pready is awaited, never assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{1'h1, 1'h0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'h1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge mclk);
			if (rsp.pready === 1'h1) begin
				break;
			end
			if (i == 20) begin
				fails++;
				report_and_stop;
			end
		end
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(1'h0, a, 32'h0);
		chk(n, x, q);
	endtask
	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task do_reset;
		@(posedge mclk);
		rst <= 1'h1;
		repeat (5) @(posedge mclk);
		#1;
		chk("rst oe", 8'h00, poe);
		chk("rst pu", 8'hFF, ppu);
		@(posedge mclk);
		rst <= 1'h0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rd(`EBPM_OFS_PF_PER, 32'h0000FE00, "pf sel");
		rd(`EBPM_OFS_PF_PUR, 32'h0000FE00, "pf pu");
		rd(`EBPM_OFS_PB_PUR, 32'h1, "pb pu");
		rd(`EBPM_OFS_BUS_CTRL, 32'h0, "drive");
		rd(8'h28, 32'h0, "bad data");
		chk("bad err", 32'h1, e);
	endtask
	// table order leaves the address function chosen at the end
	task t_strap;
		logic [2:0] tab [4];
		logic a;
		tab = '{3'h0, 3'h6, 3'h2, 3'h1};
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			{sec, mode, boot} <= tab[k];
			do_reset;
			a = tab[k][0] | (tab[k][1] & ~tab[k][2]);
			rd(`EBPM_OFS_STATUS, {27'h0, a, a, tab[k]}, "straps");
		end
	endtask
	task t_bus;
		@(posedge mclk);
		act <= 1'h1;
		wr <= 1'h1;
		atop <= 1'h1;
		dout <= 7'h5A;
		settle;
		chk("wr oe", 8'hFF, poe);
		chk("wr out", 8'hB5, pout);
		chk("wr ctl", 32'h1, ctl);
		@(posedge mclk);
		wr <= 1'h0;
		mem_en <= 1'h1;
		mval <= 8'h6A;
		settle;
		chk("rd oe", 8'h01, poe);
		chk("rd in", 7'h35, din);
		@(posedge mclk);
		act <= 1'h0;
		mem_en <= 1'h0;
		settle;
		chk("idle oe", 8'h00, poe);
		chk("idle ctl", 32'h0, ctl);
		apb(1'h1, `EBPM_OFS_BUS_CTRL, 32'h1);
		settle;
		chk("drv oe", 8'hFF, poe);
		chk("drv ctl", 32'h1, ctl);
		apb(1'h1, `EBPM_OFS_BUS_CTRL, 32'h0);
	endtask
	task t_gpio_f;
		apb(1'h1, `EBPM_OFS_PF_PER, 32'h0);
		apb(1'h1, `EBPM_OFS_PF_DDR, 32'hAA00);
		apb(1'h1, `EBPM_OFS_PF_DATA, 32'hFE00);
		@(posedge mclk);
		mem_en <= 1'h1;
		mval <= 8'h00;
		act <= 1'h1;
		wr <= 1'h1;
		settle;
		chk("gp oe", 8'hAA, poe & 8'hFE);
		chk("gp out", 8'hAA, pout & 8'hAA);
		chk("gp din", 7'h00, din);
		rd(`EBPM_OFS_PF_DATA, 32'hAA00, "gp in");
		@(posedge mclk);
		act <= 1'h0;
		wr <= 1'h0;
		mem_en <= 1'h0;
		apb(1'h1, `EBPM_OFS_PF_PER, 32'hFE00);
	endtask
	task t_pull;
		apb(1'h1, `EBPM_OFS_PF_PUR, 32'hFC00);
		apb(1'h1, `EBPM_OFS_PB_PUR, 32'h0);
		settle;
		chk("pull", 8'hFC, ppu);
	endtask
	task t_pb;
		apb(1'h1, `EBPM_OFS_PB_PER, 32'h0);
		apb(1'h1, `EBPM_OFS_PB_DDR, 32'h1);
		apb(1'h1, `EBPM_OFS_PB_DATA, 32'h1);
		settle;
		chk("pb oe", 32'h1, poe[0]);
		chk("pb out", 32'h1, pout[0]);
		rd(`EBPM_OFS_PB_DATA, 32'h1, "pb din");
		apb(1'h1, `EBPM_OFS_PB_DDR, 32'h0);
		settle;
		chk("pb in", 32'h0, poe[0]);
		apb(1'h0, `EBPM_OFS_STATUS, 32'h0);
		chk("pb sel", 32'h0, q[4]);
	endtask
	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		{rst, act, wr, atop, boot, mode, sec, mem_en} = 8'h80;
		{dout, mval, req} = '0;
		fails = 0;
		n_checks = 0;
		do_reset;
		t_regs;
		t_strap;
		t_bus;
		t_gpio_f;
		t_pull;
		t_pb;
		report_and_stop;
	end
endmodule
